// ### hdl/kwr_regs.svh
// Purpose: Register map, field positions, reset values and counts for
//          the key wakeup release block.
// Assumes: 8-bit register port, one clock at 25 MHz.
// Notes:   Definitions only.
`ifndef KWR_REGS_SVH
`define KWR_REGS_SVH

`define KWR_ADDR_W            8
`define KWR_DATA_W            8
`define KWR_WAKE_N            4
`define KWR_ST_W              3

// Register byte addresses
`define KWR_ADDR_WAKE_ENABLE  8'h31
`define KWR_ADDR_CTRL         8'h32
`define KWR_ADDR_STATUS       8'h33
`define KWR_ADDR_MASK         8'h34
`define KWR_ADDR_STATE        8'h35

// key_wake_enable fields: bit 7 pin d down to bit 4 pin a
`define KWR_EN_HI             7
`define KWR_EN_LO             4
`define KWR_EN_RST            4'h0

// Control fields
`define KWR_CTRL_STOP_BIT     0
`define KWR_CTRL_RELEASE_METHOD_SELECT_BIT     1
`define KWR_CTRL_RELEASE_METHOD_SELECT_RST     1'b0

// Status and mask fields
`define KWR_ST_RELEASE        0
`define KWR_ST_WAKE_EDGE      1
`define KWR_ST_GUARD_HIT      2
`define KWR_ST_RST            3'h0
`define KWR_MASK_RST          3'h0

// State register fields
`define KWR_STATE_STOP_BIT    0
`define KWR_STATE_GUARD_BIT   1
`define KWR_STATE_DED_BIT     2
`define KWR_STATE_WAKE_LO     4

// Clocks per instruction cycle and guard length in instruction cycles
`define KWR_INSTR_CLKS        4
`define KWR_DIV_W             2
`define KWR_DIV_LAST          2'h3
`define KWR_GUARD_CYCLES      3
`define KWR_GUARD_W           2
`define KWR_GUARD_LAST        2'h2

`endif

// ### hdl/kwr_pkg.sv
// Purpose: Types shared by the key wakeup release block.
// Assumes: kwr_regs.svh holds all widths except the 2-bit kwr_mode_t enum.
// Notes:   State of the block is one packed struct.
`include "kwr_regs.svh"

package kwr_pkg;

  typedef enum logic [1:0] {
    KWR_RUN,
    KWR_GUARD,
    KWR_STOPPED
  } kwr_mode_t;

  typedef struct packed {
    logic [`KWR_ADDR_W-1:0] addr;
    logic [`KWR_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } kwr_bus_req_t;

  typedef struct packed {
    logic                   dedicated;
    logic [`KWR_WAKE_N-1:0] wake;
  } kwr_pins_t;

  typedef struct packed {
    kwr_pins_t               sync1;
    kwr_pins_t               sync2;
    kwr_pins_t               prev;
    logic [`KWR_WAKE_N-1:0]  enable;
    logic                    release_method_select;
    logic [`KWR_ST_W-1:0]    status;
    logic [`KWR_ST_W-1:0]    mask;
    kwr_mode_t               mode;
    logic [`KWR_DIV_W-1:0]   div;
    logic [`KWR_GUARD_W-1:0] guard;
    logic [`KWR_DATA_W-1:0]  rdata;
    logic                    release_p;
    logic                    warm_p;
    logic                    irq;
    logic                    in_stop;
  } kwr_state_t;

endpackage : kwr_pkg

// ### hdl/kwr_key_wakeup_release.sv
// Purpose: Key wakeup logic that forms the stop-mode release signal from
//          a dedicated release pin and four general wake pins.
// Assumes: Pins are asynchronous and pass two flip-flops; register port
//          answers reads one cycle later; one clock at 25 MHz.
// Notes:   Stop entry is a write of the stop bit in the control register.
//
// Notes on behaviour
// - Stop release is accepted from four wake pins besides the dedicated release pin.
// - Each wake pin has its own enable bit for stop release.
// - The enables sit in bits 7 to 4 of key_wake_enable, 1 enables, write-only.
// - A rising or falling edge on any enabled wake pin releases stop mode.
// - The release signal is the OR of the dedicated pin term and the wake terms.
// - The dedicated pin releases on a high level in level mode, a rising edge in edge mode.
// - Wake-pin release needs level mode; in edge mode wake pins cannot release.
// - Release is ignored for three instruction cycles after stop entry.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns

`include "kwr_regs.svh"

module kwr_key_wakeup_release
  import kwr_pkg::*;
(
  input  wire logic                   core_clk_in,
  input  wire logic                   reset_in,
  input  wire kwr_bus_req_t           bus_req_in,
  output logic [`KWR_DATA_W-1:0]      rdata_out,
  input  wire kwr_pins_t              pins_in,
  output logic                        stop_mode_out,
  output logic                        stop_release_out,
  output logic                        warmup_start_out,
  output logic                        irq_out
);

  kwr_state_t             s_q;
  kwr_state_t             s_d;

  logic [`KWR_WAKE_N-1:0] wake_edges;
  logic                   ded_level;
  logic                   ded_rise;
  logic                   ded_term;
  logic                   wake_term;
  logic                   release_req;
  logic                   instr_en;
  logic                   wr_enable;
  logic                   wr_ctrl;
  logic                   wr_mask;
  logic                   rd_status;
  logic                   stop_cmd;
  logic [`KWR_ST_W-1:0]   st_set;

  // Edges are taken between the second sync stage and the stage after it,
  // so the metastable first stage feeds nothing but the second
  assign wake_edges  = (s_q.sync2.wake ^ s_q.prev.wake) & s_q.enable;
  assign ded_level   = s_q.sync2.dedicated;
  assign ded_rise    = s_q.sync2.dedicated & ~s_q.prev.dedicated;

  // Level mode: a high pin releases; edge mode: only a rising edge
  assign ded_term    = s_q.release_method_select ? ded_level : ded_rise;

  // Wake pins only count in level mode; in edge mode they are shut out
  assign wake_term   = s_q.release_method_select & (|wake_edges);

  // One release request for both sources
  assign release_req = ded_term | wake_term;

  // Instruction-cycle enable from the free divider
  assign instr_en    = (s_q.div == `KWR_DIV_LAST);

  assign wr_enable   = bus_req_in.wr
                       && (bus_req_in.addr == `KWR_ADDR_WAKE_ENABLE);
  assign wr_ctrl     = bus_req_in.wr
                       && (bus_req_in.addr == `KWR_ADDR_CTRL);
  assign wr_mask     = bus_req_in.wr
                       && (bus_req_in.addr == `KWR_ADDR_MASK);
  assign rd_status   = bus_req_in.rd
                       && (bus_req_in.addr == `KWR_ADDR_STATUS);
  assign stop_cmd    = wr_ctrl && bus_req_in.wdata[`KWR_CTRL_STOP_BIT];

  always_comb begin
    s_d           = s_q;
    st_set        = '0;
    s_d.rdata     = '0;
    s_d.release_p = 1'b0;
    s_d.warm_p    = 1'b0;

    s_d.sync1     = pins_in;
    s_d.sync2     = s_q.sync1;
    s_d.prev      = s_q.sync2;

    if (instr_en) begin
      s_d.div = '0;
    end else begin
      s_d.div = s_q.div + `KWR_DIV_W'(1);
    end

    // Register writes
    if (wr_enable) begin
      s_d.enable = bus_req_in.wdata[`KWR_EN_HI:`KWR_EN_LO];
    end
    if (wr_ctrl) begin
      s_d.release_method_select = bus_req_in.wdata[`KWR_CTRL_RELEASE_METHOD_SELECT_BIT];
    end
    if (wr_mask) begin
      s_d.mask = bus_req_in.wdata[`KWR_ST_W-1:0];
    end

    // Stop sequencing
    case (s_q.mode)
      KWR_RUN: begin
        if (stop_cmd) begin
          s_d.mode    = KWR_GUARD;
          s_d.in_stop = 1'b1;
          s_d.guard   = '0;
          // Restart the divider so the guard is exactly three cycles long
          s_d.div     = '0;
        end
      end
      KWR_GUARD: begin
        // Requests here are dropped, not held over to the stopped state
        if (release_req) begin
          st_set[`KWR_ST_GUARD_HIT] = 1'b1;
        end
        if (instr_en) begin
          if (s_q.guard == `KWR_GUARD_LAST) begin
            s_d.mode  = KWR_STOPPED;
            s_d.guard = '0;
          end else begin
            s_d.guard = s_q.guard + `KWR_GUARD_W'(1);
          end
        end
      end
      KWR_STOPPED: begin
        // The pin samplers keep running here, standing in for the
        // clockless edge latch of the real stop state
        if (release_req) begin
          s_d.mode                   = KWR_RUN;
          s_d.in_stop                = 1'b0;
          s_d.release_p              = 1'b1;
          s_d.warm_p                 = 1'b1;
          st_set[`KWR_ST_RELEASE]    = 1'b1;
          st_set[`KWR_ST_WAKE_EDGE]  = wake_term;
        end
      end
      default: begin
        s_d.mode    = KWR_RUN;
        s_d.in_stop = 1'b0;
      end
    endcase

    // Read-to-clear status; a new event in the same cycle wins
    if (rd_status) begin
      s_d.status = st_set;
    end else begin
      s_d.status = s_q.status | st_set;
    end
    s_d.irq = |(s_d.status & s_d.mask);

    // Read data, valid in the cycle after the strobe only
    if (bus_req_in.rd) begin
      case (bus_req_in.addr)
        `KWR_ADDR_CTRL: begin
          s_d.rdata[`KWR_CTRL_RELEASE_METHOD_SELECT_BIT] = s_q.release_method_select;
        end
        `KWR_ADDR_STATUS: begin
          s_d.rdata[`KWR_ST_W-1:0] = s_q.status;
        end
        `KWR_ADDR_MASK: begin
          s_d.rdata[`KWR_ST_W-1:0] = s_q.mask;
        end
        `KWR_ADDR_STATE: begin
          s_d.rdata[`KWR_STATE_STOP_BIT]  = s_q.in_stop;
          s_d.rdata[`KWR_STATE_GUARD_BIT] = (s_q.mode == KWR_GUARD);
          s_d.rdata[`KWR_STATE_DED_BIT]   = s_q.sync2.dedicated;
          s_d.rdata[`KWR_STATE_WAKE_LO +: `KWR_WAKE_N] = s_q.sync2.wake;
        end
        default: begin
          // Enable register is write-only; unmapped addresses read zero
          s_d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_q           <= '0;
      s_q.enable    <= `KWR_EN_RST;
      s_q.release_method_select      <= `KWR_CTRL_RELEASE_METHOD_SELECT_RST;
      s_q.status    <= `KWR_ST_RST;
      s_q.mask      <= `KWR_MASK_RST;
      s_q.mode      <= KWR_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_out        = s_q.rdata;
  assign stop_mode_out    = s_q.in_stop;
  assign stop_release_out = s_q.release_p;
  assign warmup_start_out = s_q.warm_p;
  assign irq_out          = s_q.irq;

endmodule : kwr_key_wakeup_release

// ### test/kwr_key_wakeup_release_props.sv
// Purpose: Checker of stop entry, guard, release and read-port timing.
// Assumes: Sees only the top-level ports; guard of 12 clocks.
// Notes:   Pin-to-release causes are judged by the bench.
`timescale 1ns/1ns

`include "kwr_regs.svh"

module kwr_checker
  import kwr_pkg::*;
(
  input wire logic                   core_clk_in,
  input wire logic                   reset_in,
  input wire kwr_bus_req_t           bus_req_in,
  input wire logic [`KWR_DATA_W-1:0] rdata_out,
  input wire kwr_pins_t              pins_in,
  input wire logic                   stop_mode_out,
  input wire logic                   stop_release_out,
  input wire logic                   warmup_start_out,
  input wire logic                   irq_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  sequence stop_cmd_s;
    bus_req_in.wr && bus_req_in.addr == `KWR_ADDR_CTRL &&
      bus_req_in.wdata[0] && !stop_mode_out;
  endsequence
  // Twelve clocks of guard, split to keep each repetition short
  sequence guard_quiet_s;
    !stop_release_out [*8] ##1 !stop_release_out [*4];
  endsequence

  stop_entry_a: assert property (stop_cmd_s |=> stop_mode_out)
    else $error("stop command did not enter stop mode");
  guard_quiet_a: assert property ($rose(stop_mode_out) |-> guard_quiet_s)
    else $error("release seen inside the guard time");
  warm_pair_a: assert property (stop_release_out == warmup_start_out)
    else $error("warm-up start not paired with release");
  release_ends_a: assert property (stop_release_out |->
    $past(stop_mode_out) && !stop_mode_out)
    else $error("release pulse without leaving stop mode");
  release_pulse_a: assert property (stop_release_out |=> !stop_release_out)
    else $error("release pulse longer than one cycle");
  stop_exit_a: assert property ($fell(stop_mode_out) |-> stop_release_out)
    else $error("stop mode left without a release");
  read_idle_a: assert property (!$past(bus_req_in.rd) |-> rdata_out == 8'h00)
    else $error("read data outside the answer cycle");
  wo_read_a: assert property ($past(bus_req_in.rd) &&
    $past(bus_req_in.addr) == `KWR_ADDR_WAKE_ENABLE |-> rdata_out == 8'h00)
    else $error("write-only enables read back");
endmodule : kwr_checker

bind kwr_key_wakeup_release kwr_checker i_chk (
  .core_clk_in      (core_clk_in),
  .reset_in         (reset_in),
  .bus_req_in       (bus_req_in),
  .rdata_out        (rdata_out),
  .pins_in          (pins_in),
  .stop_mode_out    (stop_mode_out),
  .stop_release_out (stop_release_out),
  .warmup_start_out (warmup_start_out),
  .irq_out          (irq_out)
);

// ### test/kwr_key_model.sv
// Purpose: Key switches driving the release and wake pins.
// Assumes: Pins have pull resistors, so they never float.
// Notes:   Levels only move when the bench commands them.
`timescale 1ns/1ns

module kwr_key_model
  import kwr_pkg::*;
(
  input  wire logic      core_clk_in,
  input  wire kwr_pins_t cmd_in,
  output kwr_pins_t      pins_out
);
  initial pins_out = '0;
  // Steady levels between wake events
  always @(posedge core_clk_in) pins_out <= cmd_in;
endmodule : kwr_key_model

// ### test/kwr_key_wakeup_release_tb_top.sv
// Purpose: Self-checking bench for the key wakeup release block.
// Assumes: Guard of 12 clocks; read data one cycle after the strobe.
// Notes:   Read results pass through a queue of expected bytes.
`timescale 1ns/1ns

`include "kwr_regs.svh"

module kwr_key_wakeup_release_tb_top
  import kwr_pkg::*;
;
  logic         core_clk_in = 1'b0;
  logic         reset_in    = 1'b1;
  kwr_bus_req_t req         = '0;
  kwr_pins_t    cmd         = '0;
  kwr_pins_t    pins;
  logic [7:0]   rdata;
  logic         stop_m, rel, warm, irq;
  logic         rd_pend     = 1'b0;
  logic [7:0]   exp_q[$];
  int           num_errors  = 0;
  int           compares    = 0;
  int           cyc         = 0;
  integer       seed        = 32'h8d37_2889;

  kwr_key_model i_keys (.core_clk_in(core_clk_in), .cmd_in(cmd),
    .pins_out(pins));
  kwr_key_wakeup_release i_dut (.core_clk_in(core_clk_in),
    .reset_in(reset_in), .bus_req_in(req), .rdata_out(rdata),
    .pins_in(pins), .stop_mode_out(stop_m), .stop_release_out(rel),
    .warmup_start_out(warm), .irq_out(irq));

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic give_verdict;
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // One access, then a gap cycle; a read notes its expected byte
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w) exp_q.push_back(d);
    @(posedge core_clk_in);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
  endtask : bus

  task automatic wait_rel(input logic exp);
    logic seen;
    logic wseen;
    seen  = 1'b0;
    wseen = 1'b0;
    repeat (40) begin
      @(posedge core_clk_in);
      if (rel === 1'b1) seen = 1'b1;
      if (warm === 1'b1) wseen = 1'b1;
    end
    cmp_bit(seen, exp);
    cmp_bit(wseen, exp);
    cmp_bit(stop_m, !exp);
  endtask : wait_rel

  initial forever #20 core_clk_in = ~core_clk_in;

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (rd_pend) cmp_byte(rdata, exp_q.pop_front());
    rd_pend <= req.rd;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    cmd.wake = 4'($random(seed));
    repeat (20) @(posedge core_clk_in);
    reset_in <= 1'b0;
    bus(1'b0, `KWR_ADDR_WAKE_ENABLE, 8'h00);
    bus(1'b0, 8'h40, 8'h00);
    // Pins were set up as inputs by software beforehand
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `KWR_ADDR_WAKE_ENABLE, 8'h10 << i);
      bus(1'b1, `KWR_ADDR_CTRL, 8'h03);
      repeat (16) @(posedge core_clk_in);
      cmd.wake[(i + 1) % 4] <= ~cmd.wake[(i + 1) % 4];
      wait_rel(1'b0);
      cmd.wake[i] <= ~cmd.wake[i];
      wait_rel(1'b1);
      bus(1'b0, `KWR_ADDR_STATUS, 8'h03);
      $display("test wake pin %0d done", i);
    end
    bus(1'b1, `KWR_ADDR_WAKE_ENABLE, 8'hf0);
    bus(1'b1, `KWR_ADDR_CTRL, 8'h01);
    repeat (16) @(posedge core_clk_in);
    cmd.wake[0] <= ~cmd.wake[0];
    wait_rel(1'b0);
    cmd.dedicated <= 1'b1;
    wait_rel(1'b1);
    bus(1'b0, `KWR_ADDR_STATE, {cmd.wake, 4'h4});
    bus(1'b0, `KWR_ADDR_STATUS, 8'h01);
    cmd.dedicated <= 1'b0;
    $display("test edge mode done");
    bus(1'b1, `KWR_ADDR_WAKE_ENABLE, 8'h00);
    bus(1'b1, `KWR_ADDR_MASK, 8'h05);
    bus(1'b0, `KWR_ADDR_MASK, 8'h05);
    bus(1'b1, `KWR_ADDR_CTRL, 8'h03);
    cmd.dedicated <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    cmd.dedicated <= 1'b0;
    wait_rel(1'b0);
    cmp_bit(irq, 1'b1);
    bus(1'b0, `KWR_ADDR_STATUS, 8'h04);
    repeat (2) @(posedge core_clk_in);
    cmp_bit(irq, 1'b0);
    cmd.dedicated <= 1'b1;
    wait_rel(1'b1);
    cmp_bit(irq, 1'b1);
    bus(1'b0, `KWR_ADDR_STATUS, 8'h01);
    cmd.dedicated <= 1'b0;
    // Release method reads back; the stop command bit reads zero
    bus(1'b0, `KWR_ADDR_CTRL, 8'h02);
    // Let the last read answer reach the compare before the verdict
    repeat (2) @(posedge core_clk_in);
    $display("test guard and interrupt done");
    give_verdict();
  end
endmodule : kwr_key_wakeup_release_tb_top
